// ==== rsc_defs.svh ====
/*
 * Constants of the reset source controller: register indices, bit
 * positions, reset values and timing counts.
 * Assumes it is included once per compile unit by its bare name.
 */
// Behaviour
// - monitor enable bit 7 switches monitor
// - monitor resets only when enabled and selected
// - status bit 6 shows monitor output
// - control bits 5:0 read zero, writes ignored
// - low reset pin forces reset
// - pin reset sets pin flag bit 0
// - clock detector resets on stuck clock
// - clock detector flag bit 2 shows cause
// - writing bit 2 enables or disables detector
// - writing bit 5 enables comparator reset
// - low comparator output causes reset when enabled
// - comparator flag shows comparator caused reset
// - only power resets drive the pin
// - watchdog enabled at mclk over 12
// - missed watchdog update resets, sets flag
// - illegal flash access causes reset
// - flash write with monitor off is error
// - flash error sets flag bit 6
// - writing bit 4 forces reset, flag reads 1
// - power or monitor reset sets flag bit 1
// - monitor enabled at power-on, kept otherwise
// - watchdog flag bit 3 shows watchdog cause
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// register indices; byte address is four times the index
`define RSC_IDX_SMC 8'hFF
`define RSC_IDX_RSR 8'hEF
`define RSC_IDX_WDC 8'hF0

// supply_monitor_control fields
`define RSC_SMC_EN 7
`define RSC_SMC_STAT 6

// reset_source_register fields
`define RSC_RSR_PIN 0
`define RSC_RSR_PWR 1
`define RSC_RSR_CLKDET 2
`define RSC_RSR_WATCHDOG 3
`define RSC_RSR_SW 4
`define RSC_RSR_CMP 5
`define RSC_RSR_FERR 6

// watchdog_control fields
`define RSC_WDC_EN 0
`define RSC_WDC_KICK 1

// reset values
`define RSC_RSR_POR 7'h02
`define RSC_MON_EN_POR 1'b1
`define RSC_WATCHDOG_EN_RST 1'b1

// timing
`define RSC_CLK_MHZ 250
`define RSC_HOLD_CYCLES 8'h10
`define RSC_WATCHDOG_DIV 4'hC
`define RSC_CLKDET_TIMEOUT_NS 1000
`define RSC_CLKDET_CYCLES ((`RSC_CLKDET_TIMEOUT_NS * `RSC_CLK_MHZ + 999) / 1000)

`endif

// ==== rsc_pkg.sv ====
/*
 * Types of the reset source controller: state enum, flash request
 * carrier and the register state of the controller.
 * Assumes nothing of its surroundings.
 */
package rsc_pkg;

  typedef enum logic [1:0] {
    RSC_ST_RUN  = 2'b01,
    RSC_ST_HOLD = 2'b10
  } rsc_state_t;

  typedef enum logic [1:0] {
    RSC_FOP_FETCH = 2'h0,
    RSC_FOP_TABLE = 2'h1,
    RSC_FOP_WRITE = 2'h2,
    RSC_FOP_ERASE = 2'h3
  } rsc_flash_op_t;

  typedef struct packed {
    logic valid;
    rsc_flash_op_t op;
    logic [15:0] addr;
    logic blocked;
  } rsc_flash_req_t;

  typedef struct packed {
    rsc_state_t st;
    logic [7:0] hold_cnt;
    logic [6:0] flags;
    logic mon_en;
    logic mon_sel;
    logic clkdet_en;
    logic cmp_en;
    logic watchdog_en;
    logic [3:0] pre;
    logic [15:0] watchdog_cnt;
    logic [11:0] clkdet_cnt;
    logic clk_prev;
    logic sys_rst_n;
    logic pin_o;
    logic pin_oe;
    logic avs_wait;
    logic [31:0] avs_rdata;
  } rsc_regs_t;

endpackage

// ==== rsc_reset_source_controller.sv ====
/*
 * Reset source controller: gathers the reset causes, holds the system
 * reset, records the last cause and serves its registers on Avalon-MM.
 * Assumes all inputs synchronous to i_mclk; i_rst_n is the power-on reset.
 */
`timescale 1ns/1ns
`include "rsc_defs.svh"

module rsc_reset_source_controller #(
  parameter logic [15:0] WATCHDOG_LIMIT = 16'hFFFF,
  parameter logic [15:0] USER_LIMIT = 16'h7FFF
) (
  input wire logic i_mclk,                        // 250 MHz clock
  input wire logic i_rst_n,                       // power-on reset
  input wire logic [7:0] i_avs_address,           // word index
  input wire logic i_avs_read,                    // read request
  input wire logic i_avs_write,                   // write request
  input wire logic [31:0] i_avs_writedata,        // write data
  output logic [31:0] o_avs_readdata,             // read data
  output logic o_avs_waitrequest,                 // stall
  input wire logic i_rst_pin_n,                   // reset pin level
  output logic o_rst_pin_o,                       // reset pin drive value
  output logic o_rst_pin_oe,                      // reset pin drive enable
  input wire logic i_supply_ok,                   // monitor output, above threshold
  output logic o_supply_monitor_en,               // monitor circuit on
  input wire logic i_cmp_out,                     // comparator output
  input wire logic i_system_clock,                // monitored system clock
  input wire rsc_pkg::rsc_flash_req_t i_flash_req, // flash access
  output logic o_sys_rst_n                        // system reset
);

  rsc_pkg::rsc_regs_t q;
  rsc_pkg::rsc_regs_t d;

  logic bus_req;
  logic do_write;
  logic wr_smc;
  logic wr_rsr;
  logic wr_wdc;
  logic watchdog_tick;
  logic kick;
  logic c_pin;
  logic c_pwr;
  logic c_clkdet;
  logic c_cmp;
  logic c_watchdog;
  logic c_ferr;
  logic c_sw;
  logic flash_bad;
  logic [6:0] cause;
  logic [31:0] rd;
  logic extend;

  assign o_avs_readdata = q.avs_rdata;
  assign o_avs_waitrequest = q.avs_wait;
  assign o_rst_pin_o = q.pin_o;
  assign o_rst_pin_oe = q.pin_oe;
  assign o_supply_monitor_en = q.mon_en;
  assign o_sys_rst_n = q.sys_rst_n;

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  always_comb begin
    bus_req = i_avs_read | i_avs_write;
    // write lands at the edge where the master sees waitrequest low
    do_write = i_avs_write & ~q.avs_wait;
    wr_smc = do_write & (i_avs_address == `RSC_IDX_SMC);
    wr_rsr = do_write & (i_avs_address == `RSC_IDX_RSR);
    wr_wdc = do_write & (i_avs_address == `RSC_IDX_WDC);
    rd = 32'h0000_0000;
    unique case (i_avs_address)
      `RSC_IDX_SMC: begin
        rd[`RSC_SMC_EN] = q.mon_en;
        rd[`RSC_SMC_STAT] = i_supply_ok;
      end
      `RSC_IDX_RSR: begin
        rd[6:0] = q.flags;
      end
      `RSC_IDX_WDC: begin
        rd[`RSC_WDC_EN] = q.watchdog_en;
      end
      default: begin
        rd = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // reset causes

  always_comb begin
    watchdog_tick = (q.pre == `RSC_WATCHDOG_DIV - 4'h1);
    kick = wr_wdc & i_avs_writedata[`RSC_WDC_KICK];
    c_pin = ~i_rst_pin_n;
    c_pwr = q.mon_en & q.mon_sel & ~i_supply_ok;
    // counts mclk cycles with no system clock edge
    c_clkdet = q.clkdet_en & (i_system_clock == q.clk_prev)
      & (q.clkdet_cnt == 12'(`RSC_CLKDET_CYCLES));
    c_cmp = q.cmp_en & ~i_cmp_out;
    c_watchdog = q.watchdog_en & watchdog_tick & ~kick
      & (q.watchdog_cnt == WATCHDOG_LIMIT);
    flash_bad = (i_flash_req.addr > USER_LIMIT) | i_flash_req.blocked;
    if ((i_flash_req.op == rsc_pkg::RSC_FOP_WRITE) || (i_flash_req.op == rsc_pkg::RSC_FOP_ERASE)) begin
      flash_bad = flash_bad | ~q.mon_en;
    end
    c_ferr = i_flash_req.valid & flash_bad;
    c_sw = wr_rsr & i_avs_writedata[`RSC_RSR_SW];
    // one flag per reset, power first since it outranks the rest
    cause = 7'h00;
    if (c_pwr) begin
      cause[`RSC_RSR_PWR] = 1'b1;
    end else if (c_pin) begin
      cause[`RSC_RSR_PIN] = 1'b1;
    end else if (c_clkdet) begin
      cause[`RSC_RSR_CLKDET] = 1'b1;
    end else if (c_cmp) begin
      cause[`RSC_RSR_CMP] = 1'b1;
    end else if (c_watchdog) begin
      cause[`RSC_RSR_WATCHDOG] = 1'b1;
    end else if (c_ferr) begin
      cause[`RSC_RSR_FERR] = 1'b1;
    end else if (c_sw) begin
      cause[`RSC_RSR_SW] = 1'b1;
    end
    // pin and supply keep the reset asserted while they stay active, if their own flag shows they caused it
    extend = (q.flags[`RSC_RSR_PIN] & c_pin) | (q.flags[`RSC_RSR_PWR] & ~i_supply_ok);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    // bus slave: one wait cycle, then one cycle of answer
    if (bus_req && q.avs_wait) begin
      d.avs_wait = 1'b0;
      d.avs_rdata = rd;
    end else begin
      d.avs_wait = 1'b1;
    end
    d.clk_prev = i_system_clock;
    if (i_system_clock != q.clk_prev) begin
      d.clkdet_cnt = 12'h000;
    end else if (q.clkdet_cnt != 12'(`RSC_CLKDET_CYCLES)) begin
      d.clkdet_cnt = q.clkdet_cnt + 12'h001;
    end
    d.pre = watchdog_tick ? 4'h0 : q.pre + 4'h1;
    if (kick) begin
      d.watchdog_cnt = 16'h0000;
    end else if (q.watchdog_en && watchdog_tick && q.watchdog_cnt != WATCHDOG_LIMIT) begin
      d.watchdog_cnt = q.watchdog_cnt + 16'h0001;
    end
    if (wr_smc) begin
      d.mon_en = i_avs_writedata[`RSC_SMC_EN];
    end
    if (wr_rsr) begin
      d.mon_sel = i_avs_writedata[`RSC_RSR_PWR];
      d.clkdet_en = i_avs_writedata[`RSC_RSR_CLKDET];
      d.cmp_en = i_avs_writedata[`RSC_RSR_CMP];
    end
    if (wr_wdc) begin
      d.watchdog_en = i_avs_writedata[`RSC_WDC_EN];
    end
    unique case (q.st)
      rsc_pkg::RSC_ST_RUN: begin
        if (cause != 7'h00) begin
          d.st = rsc_pkg::RSC_ST_HOLD;
          d.flags = cause;
          d.sys_rst_n = 1'b0;
          d.hold_cnt = 8'h00;
          // only a supply reset drives the pin low
          d.pin_oe = cause[`RSC_RSR_PWR];
          d.mon_sel = 1'b0;
          d.clkdet_en = 1'b0;
          d.cmp_en = 1'b0;
          d.watchdog_en = `RSC_WATCHDOG_EN_RST;
          d.watchdog_cnt = 16'h0000;
          d.pre = 4'h0;
          d.mon_en = q.mon_en;
        end
      end
      rsc_pkg::RSC_ST_HOLD: begin
        d.mon_sel = 1'b0;
        d.clkdet_en = 1'b0;
        d.cmp_en = 1'b0;
        d.watchdog_en = `RSC_WATCHDOG_EN_RST;
        d.watchdog_cnt = 16'h0000;
        if (extend) begin
          d.hold_cnt = 8'h00;
        end else if (q.hold_cnt == `RSC_HOLD_CYCLES - 8'h01) begin
          d.st = rsc_pkg::RSC_ST_RUN;
          d.sys_rst_n = 1'b1;
          d.pin_oe = 1'b0;
        end else begin
          d.hold_cnt = q.hold_cnt + 8'h01;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers; power-on starts in hold with the power flag set

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.st <= rsc_pkg::RSC_ST_HOLD;
      q.flags <= `RSC_RSR_POR;
      q.mon_en <= `RSC_MON_EN_POR;
      q.watchdog_en <= `RSC_WATCHDOG_EN_RST;
      q.pin_oe <= 1'b1;
      q.avs_wait <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule

// ==== rsc_reset_source_controller_checker.sv ====
/* checker: bus answer, reset hold and pin drive timing of the controller.
   assumes it is bound onto rsc_reset_source_controller. */
`timescale 1ns/1ns
module rsc_checker (
  input wire logic i_mclk, i_rst_n, i_avs_read, i_avs_write, i_rst_pin_n, i_supply_ok, // watched inputs
  input wire logic [7:0] i_avs_address, // word index
  input wire logic [31:0] i_avs_writedata, o_avs_readdata, // bus data
  input wire logic o_avs_waitrequest, o_rst_pin_o, o_rst_pin_oe, o_supply_monitor_en, o_sys_rst_n // outputs
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] low_q;
  // saturates so a long power hold cannot wrap
  always_ff @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n) low_q <= 8'h00;
    else low_q <= o_sys_rst_n ? 8'h00 : (low_q == 8'hFF ? low_q : low_q + 8'h01);
  ////////////////////////////////////////
  AST_BUS_ANSWER: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");
  AST_BUS_IDLE: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest) else $error("bus not stalled");
  AST_PIN_RESET: assert property (!i_rst_pin_n && o_sys_rst_n |=> !o_sys_rst_n)
    else $error("pin low ignored");
  AST_PIN_QUIET: assert property ($rose(o_rst_pin_oe) |-> !$past(i_supply_ok) && $past(o_supply_monitor_en))
    else $error("pin driven without supply cause");
  AST_PIN_LOW: assert property (o_rst_pin_oe |-> !o_rst_pin_o) else $error("pin driven high");
  AST_MON_WRITE: assert property ($changed(o_supply_monitor_en) |-> $past(i_avs_write) && !$past(o_avs_waitrequest)
    && $past(i_avs_address) == 8'hFF && o_supply_monitor_en == $past(i_avs_writedata[7])) else $error("monitor enable moved");
  AST_CTRL_READ: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == 8'hFF |->
    o_avs_readdata[5:0] == 6'h00 && o_avs_readdata[31:8] == 24'h000000 && o_avs_readdata[7] == o_supply_monitor_en)
    else $error("control read wrong");
  AST_HOLD_MIN: assert property ($fell(o_sys_rst_n) |=> !o_sys_rst_n [*8]) else $error("reset too short");
  AST_HOLD_LEN: assert property ($rose(o_sys_rst_n) |-> low_q >= 8'h10) else $error("hold count short");
endmodule
bind rsc_reset_source_controller rsc_checker u_chk (.i_mclk, .i_rst_n, .i_avs_read, .i_avs_write, .i_rst_pin_n,
  .i_supply_ok, .i_avs_address, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_rst_pin_o, .o_rst_pin_oe,
  .o_supply_monitor_en, .o_sys_rst_n);

// ==== rsc_partner.sv ====
/* partner: reset pin with pull-up, supply monitor, comparator, system clock.
   assumes the bench steers the fault inputs after clock edges. */
`timescale 1ns/1ns
module rsc_partner (
  input wire logic i_mclk,       // clock
  input wire logic i_pin_oe,     // device drives pin
  input wire logic i_pin_o,      // device drive value
  input wire logic i_push_pin,   // outside pulls pin low
  input wire logic i_sag,        // supply below threshold
  input wire logic i_cmp_low,    // comparator trips
  input wire logic i_clk_stop,   // system clock stalls
  output logic o_pin_n,          // resolved pin level
  output logic o_supply_ok,      // monitor output
  output logic o_cmp_out,        // comparator output
  output logic o_system_clock    // monitored clock
);
  logic clk_q = 1'b0;
  // pull-up wins unless some party pulls low
  assign o_pin_n = !(i_push_pin || (i_pin_oe && !i_pin_o));
  assign o_supply_ok = !i_sag;
  assign o_cmp_out = !i_cmp_low;
  assign o_system_clock = clk_q;
  always @(posedge i_mclk) if (!i_clk_stop) clk_q <= ~clk_q;
endmodule

// ==== rsc_reset_source_controller_bench.sv ====
/* bench: register rows, then each reset cause and its flag.
   assumes the controller, its checker and rsc_partner are compiled. */
`timescale 1ns/1ns
module rsc_reset_source_controller_bench;
  logic i_mclk, i_rst_n, i_avs_read, i_avs_write, o_avs_waitrequest, i_rst_pin_n, o_rst_pin_o, o_rst_pin_oe;
  logic i_supply_ok, o_supply_monitor_en, i_cmp_out, i_system_clock, o_sys_rst_n, push_pin, sag, cmp_low, clk_stop;
  logic [7:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, rd;
  rsc_pkg::rsc_flash_req_t i_flash_req;
  int fails, checks;
  logic [7:0] row_a [5] = '{8'hFF, 8'hEF, 8'hFF, 8'hFF, 8'h10};
  logic row_wr [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [31:0] row_w [5] = '{32'h0, 32'h0, 32'h3F, 32'hFF, 32'hAB};
  logic [31:0] row_e [5] = '{32'hC0, 32'h02, 32'h40, 32'hC0, 32'h00};
  // short watchdog so its cause fits the run
  rsc_reset_source_controller #(.WATCHDOG_LIMIT(16'h0040)) dut (.i_mclk, .i_rst_n, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_rst_pin_n, .o_rst_pin_o, .o_rst_pin_oe,
    .i_supply_ok, .o_supply_monitor_en, .i_cmp_out, .i_system_clock, .i_flash_req, .o_sys_rst_n);
  rsc_partner partner (.i_mclk, .i_pin_oe(o_rst_pin_oe), .i_pin_o(o_rst_pin_o), .i_push_pin(push_pin), .i_sag(sag),
    .i_cmp_low(cmp_low), .i_clk_stop(clk_stop), .o_pin_n(i_rst_pin_n), .o_supply_ok(i_supply_ok),
    .o_cmp_out(i_cmp_out), .o_system_clock(i_system_clock));
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (o_avs_waitrequest !== 1'b0) begin
      fails++;
      complete_run();
    end
  endtask
  // waits for the reset, lifts every cause, then reads the flags
  task automatic await_rst(input logic [31:0] exp);
    int n;
    n = 0;
    while (o_sys_rst_n !== 1'b0 && n < 1000) begin
      @(posedge i_mclk);
      n++;
    end
    // a reset that never came is a timeout too
    if (o_sys_rst_n !== 1'b0) n = 1100;
    push_pin <= 1'b0;
    sag <= 1'b0;
    cmp_low <= 1'b0;
    clk_stop <= 1'b0;
    while (o_sys_rst_n !== 1'b1 && n < 1100) begin
      @(posedge i_mclk);
      n++;
    end
    if (n >= 1100) begin
      fails++;
      complete_run();
    end
    bus(1'b0, 8'hEF, 32'h0);
    chk(rd, exp);
    $display("reset test done, flags %h", exp);
  endtask
  task automatic flash_pulse(input logic [1:0] op, input logic [15:0] a, input logic blk);
    @(posedge i_mclk);
    i_flash_req <= '{1'b1, rsc_pkg::rsc_flash_op_t'(op), a, blk};
    @(posedge i_mclk);
    i_flash_req.valid <= 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    {i_rst_n, i_avs_read, i_avs_write, push_pin, sag, cmp_low, clk_stop} = 7'h00;
    i_avs_address = 8'h00;
    i_avs_writedata = 32'h0;
    i_flash_req = '0;
    fails = 0;
    checks = 0;
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (row_wr[i]) bus(1'b1, row_a[i], row_w[i]);
      bus(1'b0, row_a[i], 32'h0);
      chk(rd, row_e[i]);
    end
    $display("register rows done");
    bus(1'b1, 8'hEF, 32'h10);
    await_rst(32'h10);
    push_pin <= 1'b1;
    await_rst(32'h01);
    bus(1'b1, 8'hEF, 32'h04);
    clk_stop <= 1'b1;
    await_rst(32'h04);
    bus(1'b1, 8'hEF, 32'h20);
    cmp_low <= 1'b1;
    await_rst(32'h20);
    await_rst(32'h08);
    for (int k = 0; k < 4; k++) begin
      flash_pulse(k[1:0], k[0] ? 16'h0010 : 16'h8000, k[0]);
      await_rst(32'h40);
    end
    bus(1'b1, 8'hFF, 32'h00);
    flash_pulse(2'h2, 16'h0010, 1'b0);
    await_rst(32'h40);
    bus(1'b0, 8'hFF, 32'h0);
    chk(rd, 32'h40);
    bus(1'b1, 8'hFF, 32'h80);
    sag <= 1'b1;
    bus(1'b0, 8'hFF, 32'h0);
    chk(rd, 32'h80);
    chk({31'h0, o_sys_rst_n}, 32'h1);
    sag <= 1'b0;
    repeat (20) @(posedge i_mclk);
    bus(1'b1, 8'hEF, 32'h02);
    sag <= 1'b1;
    await_rst(32'h02);
    bus(1'b1, 8'hFF, 32'h00);
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    await_rst(32'h02);
    bus(1'b0, 8'hFF, 32'h0);
    chk(rd, 32'hC0);
    complete_run();
  end
endmodule
